// ### osth_defs.vh
// constants for the order-status and terminal-order handler
`ifndef OSTH_DEFS_VH
`define OSTH_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OSTH_REG_CTRL      4'h0
`define OSTH_REG_STATUS    4'h4
`define OSTH_REG_LAST      4'h8

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define OSTH_CTRL_CHMOD_BIT 0
`define OSTH_CTRL_RESET    32'h0000_0000
`define OSTH_CHMOD_RESET   1'b0

// ----------------------------------------------------------------
// order_in status byte, bit numbers as seen by the processor
// ----------------------------------------------------------------
`define OSTH_ST_XERR       0
`define OSTH_ST_LERR       1
`define OSTH_ST_CHMOD      2
`define OSTH_ST_DONE       3
`define OSTH_ST_ABN        4

// ----------------------------------------------------------------
// terminal_order bits
// ----------------------------------------------------------------
`define OSTH_TERM_INT      0
`define OSTH_TERM_CNTDONE  1
`define OSTH_TERM_CHAIN    2
`define OSTH_TERM_HALT     3

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define OSTH_RESP_OKAY     2'b00
`define OSTH_RESP_SLVERR   2'b10

`endif

// ### osth_handler.v
// device-side order_in status / terminal_order handler with axi4-lite registers
// Overview of operation
// - chaining modifier makes processor skip one doubleword
// - no chaining ready, chaining stay busy, order_out
// - accept start_io right after channel_end when ready
// - hold channel_end until device quiet
// - after unusual_end, ready on to strobe trailing edge
// - unusual_end always reportable through order_in; here a fault during an order_in is not reported unless chaining follows
// - halt in order_in cycle: ready, silent
// - halt case still interrupts, chain bit ignored
// - faults, reset switch, bad order raise unusual_end
// - unusual_end fast, no data meanwhile
// - unusual_end also sets channel_end bit
// - status bits 5 to 7 always zero
// - terminal bit 0 raises interrupt only
// - count done leads to order_in with channel_end
// - chain bit examined only after channel_end
// - interrupt pending blocks start_io until acknowledged
// - chaining requests order_out alongside interrupt
// - processor halt: unusual_end, no data cycles
// - terminal bits 4 to 7 ignored
// - status bit 0 transmission error, 1 length
// - only processor ends service; end_data either; here end_data is unused, only end_service ends it
// - one order_in per order_out taken
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "osth_defs.vh"

module osth_handler
(
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// processor side of the channel
	output reg         svc_req,
	output reg         svc_order_in,
	input  wire        svc_ack,
	output reg         request_strobe,
	input  wire        proc_ack,
	input  wire        end_service,
	input  wire        end_data,
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output reg         data_oen_n,
	input  wire        start_io,
	input  wire        halt_io,
	input  wire        ack_interrupt,
	output reg         int_req,
	// device side
	input  wire        parity_err,
	input  wire        reset_switch,
	input  wire        xmit_err,
	input  wire        length_err,
	input  wire        dev_quiet,
	output reg         cmd_valid,
	output reg  [7:0]  cmd_byte,
	output reg         busy,
	output reg         data_xfer_ok
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [2:0] ST_READY = 3'd0;	// idle, accepts start_io
localparam [2:0] ST_BUSY  = 3'd1;	// order running on the device
localparam [2:0] ST_SVC   = 3'd2;	// service requested, awaiting grant
localparam [2:0] ST_STRB  = 3'd3;	// strobe high, awaiting processor
localparam [2:0] ST_NEXT  = 3'd4;	// strobe low between bytes

reg  [2:0]  state;			// controller state
reg         to_byte;		// next strobe fetches the terminal_order
reg         rep_done;		// this order_in reports channel_end
reg         rep_abn;		// this order_in reports unusual_end
reg         done_owed;		// channel_end owed to the processor
reg         abn_owed;		// unusual_end owed to the processor
reg         inq_left;		// an order_in is still allowed
reg         xerr_seen;		// transmission error latched
reg         lerr_seen;		// incorrect length latched
reg         chain_mod;		// software chaining modifier
reg  [7:0]  last_to;		// last terminal_order seen
reg  [3:0]  aw_addr;		// latched write address
reg  [31:0] w_data;			// latched write data
reg  [3:0]  w_strb;			// latched byte enables

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// orders the device knows; anything else is refused
function order_known;
	input [7:0] ord;
	begin
		order_known = (ord[3:0] == 4'h1) || (ord[3:0] == 4'h2) || (ord[3:0] == 4'h3);
	end
endfunction

// map a register offset to a legal flag
function reg_mapped;
	input [3:0] a;
	begin
		reg_mapped = (a == `OSTH_REG_CTRL) || (a == `OSTH_REG_STATUS) || (a == `OSTH_REG_LAST);
	end
endfunction

// status byte, bit 0 in the most significant lane
wire [7:0] status_byte;
assign status_byte[7 - `OSTH_ST_XERR]  = xerr_seen;
assign status_byte[7 - `OSTH_ST_LERR]  = lerr_seen;
assign status_byte[7 - `OSTH_ST_CHMOD] = chain_mod;
assign status_byte[7 - `OSTH_ST_DONE]  = rep_done | rep_abn;
assign status_byte[7 - `OSTH_ST_ABN]   = rep_abn;
assign status_byte[2:0]                = 3'b000;

// fault sources while an order is active
wire fault_now = (state != ST_READY) && (parity_err || reset_switch);
wire start_take = start_io && (state == ST_READY) && !int_req;

// ----------------------------------------------------------------
// channel state machine
// ----------------------------------------------------------------
// transitions follow processor handshakes, device status or one timed cycle (ST_NEXT); halt_io wins over all
always @(posedge aclk)
begin
	cmd_valid <= 1'b0;
	if (!aresetn)
	begin
		state          <= ST_READY;
		to_byte        <= 1'b0;
		rep_done       <= 1'b0;
		rep_abn        <= 1'b0;
		done_owed      <= 1'b0;
		abn_owed       <= 1'b0;
		inq_left       <= 1'b0;
		xerr_seen      <= 1'b0;
		lerr_seen      <= 1'b0;
		last_to        <= 8'h00;
		cmd_byte       <= 8'h00;
		svc_req        <= 1'b0;
		svc_order_in   <= 1'b0;
		request_strobe <= 1'b0;
		data_out       <= 8'h00;
		data_oen_n     <= 1'b1;
		int_req        <= 1'b0;
	end
	else
	begin
		// interrupt acknowledge; a new request in the same cycle wins below
		if (ack_interrupt)
			int_req <= 1'b0;
		// latch error indications for the next status byte
		if (xmit_err && state != ST_READY)
			xerr_seen <= 1'b1;
		if (length_err && state != ST_READY)
			lerr_seen <= 1'b1;
		if (fault_now)
			abn_owed <= 1'b1;
		if (halt_io)
		begin
			// computer-initiated stop: quiet return, no unusual_end
			state          <= ST_READY;
			svc_req        <= 1'b0;
			request_strobe <= 1'b0;
			data_oen_n     <= 1'b1;
			done_owed      <= 1'b0;
			abn_owed       <= 1'b0;
			inq_left       <= 1'b0;
		end
		else
		begin
			case (state)
			ST_READY:
			begin
				if (start_take)
				begin
					// fresh operation: ask for order_out to fetch the command
					state        <= ST_SVC;
					svc_req      <= 1'b1;
					svc_order_in <= 1'b0;
					xerr_seen    <= 1'b0;
					lerr_seen    <= 1'b0;
					done_owed    <= 1'b0;
					abn_owed     <= 1'b0;
					inq_left     <= 1'b0;
				end
			end
			ST_BUSY:
			begin
				// unusual_end goes first and at once; channel_end waits for quiet
				if (inq_left && (abn_owed || fault_now || (done_owed && dev_quiet)))
				begin
					state        <= ST_SVC;
					svc_req      <= 1'b1;
					svc_order_in <= 1'b1;
					inq_left     <= 1'b0;
					rep_abn      <= abn_owed || fault_now;
					rep_done     <= done_owed;
				end
			end
			ST_SVC:
			begin
				if (svc_ack)
				begin
					svc_req        <= 1'b0;
					state          <= ST_STRB;
					to_byte        <= 1'b0;
					request_strobe <= 1'b1;
					data_out       <= svc_order_in ? status_byte : 8'h00;
					data_oen_n     <= !svc_order_in;
				end
			end
			ST_STRB:
			begin
				if (proc_ack)
				begin
					// trailing edge of the strobe
					request_strobe <= 1'b0;
					data_oen_n     <= 1'b1;
					if (!to_byte)
					begin
						if (!svc_order_in)
						begin
							cmd_byte  <= data_in;
							cmd_valid <= 1'b1;
							inq_left  <= 1'b1;
							if (!order_known(data_in))
								abn_owed <= 1'b1;
						end
						if (end_service)
						begin
							// only the processor closes service, here with no terminal_order
							if (!svc_order_in)
								state <= ST_BUSY;
							else
							begin
								state      <= ST_READY;
								done_owed  <= 1'b0;
								abn_owed   <= 1'b0;
							end
						end
						else
						begin
							state   <= ST_NEXT;
							to_byte <= 1'b1;
						end
					end
					else
					begin
						// terminal_order: bits 4 to 7 are never looked at
						last_to <= data_in;
						if (data_in[`OSTH_TERM_INT])
							int_req <= 1'b1;
						if (svc_order_in)
						begin
							if (data_in[`OSTH_TERM_HALT])
							begin
								state      <= ST_READY;
								done_owed  <= 1'b0;
								abn_owed   <= 1'b0;
							end
							else if (rep_abn)
							begin
								state      <= ST_READY;
								done_owed  <= 1'b0;
								abn_owed   <= 1'b0;
							end
							else if (rep_done && data_in[`OSTH_TERM_CHAIN])
							begin
								state        <= ST_SVC;
								svc_req      <= 1'b1;
								svc_order_in <= 1'b0;
								done_owed    <= 1'b0;
							end
							else
							begin
								state      <= ST_READY;
								done_owed  <= 1'b0;
							end
						end
						else
						begin
							// order_out terminal order; a dummy simply leaves us busy
							state <= ST_BUSY;
							if (data_in[`OSTH_TERM_CNTDONE])
								done_owed <= 1'b1;
							if (data_in[`OSTH_TERM_HALT])
								abn_owed <= 1'b1;
						end
					end
				end
			end
			ST_NEXT:
			begin
				// one idle cycle so the processor sees a clean strobe edge
				state          <= ST_STRB;
				request_strobe <= 1'b1;
				data_oen_n     <= 1'b1;
			end
			default:
			begin
				state <= ST_READY;
			end
			endcase
		end
	end
end

// ----------------------------------------------------------------
// registered device-side status
// ----------------------------------------------------------------
// data cycles are forbidden while unusual_end is owed
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		busy         <= 1'b0;
		data_xfer_ok <= 1'b0;
	end
	else
	begin
		busy         <= (state != ST_READY);
		data_xfer_ok <= (state == ST_BUSY) && inq_left && !abn_owed && !fault_now && !done_owed;
	end
end

// ----------------------------------------------------------------
// axi4-lite write channel
// ----------------------------------------------------------------
// address and data taken in either order, response after both
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready  <= 1'b1;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `OSTH_RESP_OKAY;
		aw_addr       <= 4'h0;
		w_data        <= 32'h0000_0000;
		w_strb        <= 4'h0;
		chain_mod     <= `OSTH_CHMOD_RESET;
	end
	else
	begin
		if (s_axi_awready && s_axi_awvalid)
		begin
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wready && s_axi_wvalid)
		begin
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
		begin
			s_axi_bvalid <= 1'b1;
			if (reg_mapped(aw_addr))
				s_axi_bresp <= `OSTH_RESP_OKAY;
			else
				s_axi_bresp <= `OSTH_RESP_SLVERR;
			// only control is writable; others ignore the data
			if (aw_addr == `OSTH_REG_CTRL && w_strb[0])
				chain_mod <= w_data[`OSTH_CTRL_CHMOD_BIT];
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid  <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// axi4-lite read channel
// ----------------------------------------------------------------
// one read at a time, answered the cycle after the address is taken
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h0000_0000;
		s_axi_rresp   <= `OSTH_RESP_OKAY;
	end
	else
	begin
		if (s_axi_arready && s_axi_arvalid)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= reg_mapped(s_axi_araddr) ? `OSTH_RESP_OKAY : `OSTH_RESP_SLVERR;
			case (s_axi_araddr)
			`OSTH_REG_CTRL:
				s_axi_rdata <= {31'h0000_0000, chain_mod};
			`OSTH_REG_STATUS:
				s_axi_rdata <= {22'h00_0000, lerr_seen, xerr_seen, inq_left, busy,
				                abn_owed, done_owed, int_req, state};
			`OSTH_REG_LAST:
				s_axi_rdata <= {16'h0000, cmd_byte, last_to};
			default:
				s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule
`default_nettype wire

// ### osth_handler_properties.sv
// port checker for the order-status handler
`timescale 1ns/1ps
`default_nettype none
module osth_handler_properties
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       svc_req,
	input wire logic       svc_order_in,
	input wire logic       request_strobe,
	input wire logic       proc_ack,
	input wire logic       end_service,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oen_n,
	input wire logic       start_io,
	input wire logic       int_req,
	input wire logic       busy
);
	// ----------------------------------------------------------------
	// byte tracking
	// ----------------------------------------------------------------
	logic term_next; // next acked byte is the terminal order
	logic abn_seen;  // last status byte carried unusual_end
	wire  is_term = request_strobe && proc_ack && term_next;

	// first byte without end_service means a terminal order follows
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			term_next <= 1'h0;
			abn_seen <= 1'h0;
		end
		else if (request_strobe && proc_ack)
		begin
			term_next <= !term_next && !end_service;
			if (!data_oen_n)
				abn_seen <= data_out[3];
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_spare_zero: assert property (!data_oen_n |-> data_out[2:0] == 3'h0)
		else $error("status spare bits set");
	chk_unusual_end_channel_end: assert property ((!data_oen_n && data_out[3]) |-> data_out[4])
		else $error("unusual_end without channel_end");
	chk_byte_steady: assert property ((request_strobe && !proc_ack) |=> (request_strobe && $stable(data_out)))
		else $error("strobe or status byte moved before ack");
	chk_oen_order_in: assert property (!data_oen_n |-> svc_order_in)
		else $error("status driven outside order_in");
	chk_int_raise: assert property ((is_term && data_in[0]) |=> int_req)
		else $error("interrupt bit ignored");
	chk_int_blocks: assert property ((start_io && int_req && !busy && !svc_req) |=> !svc_req)
		else $error("start_io taken with interrupt pending");
	chk_start_take: assert property ((start_io && !int_req && !busy && !svc_req && !request_strobe)
		|=> (svc_req && !svc_order_in))
		else $error("start_io not taken while ready");
	chk_end_ready: assert property ((is_term && svc_order_in && !data_in[2]) |-> ##2 (!busy && !svc_req))
		else $error("no return to ready without chaining");
	chk_chain_out: assert property ((is_term && svc_order_in && data_in[2] && !data_in[3] && !abn_seen)
		|-> ##[1:3] (svc_req && !svc_order_in))
		else $error("chaining did not request order_out");
	chk_halt_ready: assert property ((is_term && svc_order_in && (data_in[3] || abn_seen))
		|-> ##2 (!busy && !svc_req))
		else $error("no ready after halt or unusual_end");
	chk_count_done: assert property ((is_term && !svc_order_in && data_in[1])
		|-> ##[1:20] (svc_req && svc_order_in))
		else $error("count done without order_in");

	cover property (is_term && svc_order_in && data_in[2]);
	cover property (!data_oen_n && data_out[3]);
	cover property (start_io && int_req);
endmodule

bind osth_handler osth_handler_properties osth_handler_properties_inst
(
	.aclk, .aresetn, .svc_req, .svc_order_in, .request_strobe, .proc_ack, .end_service,
	.data_in, .data_out, .data_oen_n, .start_io, .int_req, .busy
);
`default_nettype wire

// ### osth_handler_tb_top.sv
// testbench for the order-status handler
`timescale 1ns/1ps
`default_nettype none
module osth_handler_tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0]  awaddr, araddr, wstrb, dly;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        svc_req, svc_order_in, svc_ack, request_strobe, proc_ack, end_service;
	logic        start_io, ack_interrupt, int_req, data_oen_n, busy, xmit_err, length_err;
	logic [7:0]  data_in, data_out, order_byte, to_out, to_in, n_in, last_status;
	int          n_mismatch, checked, i;

	osth_handler osth_handler_inst
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .svc_req(svc_req),
		.svc_order_in(svc_order_in), .svc_ack(svc_ack), .request_strobe(request_strobe),
		.proc_ack(proc_ack), .end_service(end_service), .end_data(1'h0), .data_in(data_in),
		.data_out(data_out), .data_oen_n(data_oen_n), .start_io(start_io), .halt_io(1'h0),
		.ack_interrupt(ack_interrupt), .int_req(int_req), .parity_err(1'h0), .reset_switch(1'h0),
		.xmit_err(xmit_err), .length_err(length_err), .dev_quiet(1'h1), .cmd_valid(),
		.cmd_byte(), .busy(busy), .data_xfer_ok()
	);

	osth_iop_model osth_iop_model_inst
	(
		.aclk(aclk), .aresetn(aresetn), .svc_req(svc_req), .svc_order_in(svc_order_in),
		.request_strobe(request_strobe), .data_out(data_out), .order_byte(order_byte),
		.to_out(to_out), .to_in(to_in), .dly(dly), .svc_ack(svc_ack), .proc_ack(proc_ack),
		.end_service(end_service), .data_in(data_in), .n_in(n_in), .last_status(last_status)
	);

	// 10 MHz clock
	initial
	begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task print_verdict;
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// one start_io run; t_in2 answers any chained order_in
	task op(input logic [7:0] o, t_out, t_in, t_in2, st, n_exp);
		logic [7:0] n0;
		@(posedge aclk);
		n0 = n_in;
		order_byte <= o;
		to_out <= t_out;
		to_in <= t_in;
		start_io <= 1'h1;
		@(posedge aclk);
		start_io <= 1'h0;
		for (i = 0; i < 300 && n_in == n0; i++)
			@(posedge aclk);
		to_in <= t_in2;
		repeat (3) @(posedge aclk);
		for (i = 0; i < 300 && (busy !== 1'h0 || svc_req !== 1'h0); i++)
			@(posedge aclk);
		chk({24'h0, last_status}, {24'h0, st});
		chk({24'h0, n_in - n0}, {24'h0, n_exp});
	endtask

	task ack_int;
		@(posedge aclk);
		ack_interrupt <= 1'h1;
		@(posedge aclk);
		ack_interrupt <= 1'h0;
		@(posedge aclk);
		chk({31'h0, int_req}, 32'h0);
	endtask

	// hang guard, far above the expected run length
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch = n_mismatch + 1;
		print_verdict;
	end

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, start_io, ack_interrupt} = 8'h00;
		{xmit_err, length_err, awaddr, araddr, wstrb, dly} = 18'h0;
		{wdata, order_byte, to_out, to_in} = 56'h0;
		n_mismatch = 0;
		checked = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		axr(4'h0, 32'h0, 2'h0);
		axw(4'h0, 32'h1, 2'h0);
		axr(4'h0, 32'h1, 2'h0);
		axw(4'hc, 32'h1, 2'h2);
		axr(4'hc, 32'h0, 2'h2);
		op(8'h01, 8'h02, 8'h00, 8'h00, 8'h30, 8'h01);
		axr(4'h8, 32'h0000_0100, 2'h0);
		axw(4'h0, 32'h0, 2'h0);
		dly <= 4'h3;
		op(8'h02, 8'h02, 8'h05, 8'h01, 8'h10, 8'h02);
		chk({31'h0, int_req}, 32'h1);
		@(posedge aclk);
		start_io <= 1'h1;
		@(posedge aclk);
		start_io <= 1'h0;
		repeat (3) @(posedge aclk);
		chk({31'h0, svc_req}, 32'h0);
		ack_int();
		dly <= 4'h0;
		op(8'h03, 8'h08, 8'h0d, 8'h0d, 8'h18, 8'h01);
		chk({31'h0, int_req}, 32'h1);
		ack_int();
		xmit_err <= 1'h1;
		length_err <= 1'h1;
		op(8'h0f, 8'hf0, 8'h00, 8'h00, 8'hd8, 8'h01);
		print_verdict;
	end
endmodule
`default_nettype wire

// ### osth_iop_model.sv
// io processor model answering service requests
`timescale 1ns/1ps
`default_nettype none
module osth_iop_model
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       svc_req,
	input  wire logic       svc_order_in,
	input  wire logic       request_strobe,
	input  wire logic [7:0] data_out,
	input  wire logic [7:0] order_byte,
	input  wire logic [7:0] to_out,
	input  wire logic [7:0] to_in,
	input  wire logic [3:0] dly,
	output var  logic       svc_ack,
	output var  logic       proc_ack,
	output var  logic       end_service,
	output var  logic [7:0] data_in,
	output var  logic [7:0] n_in,
	output var  logic [7:0] last_status
);
	logic [3:0] cnt;    // cycles the open request has waited
	logic       second; // next byte is the terminal order
	wire        take = request_strobe && !proc_ack && (cnt >= dly);

	// acks come after dly cycles; released lines toggle so stale data never looks valid
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			svc_ack <= 1'h0;
			proc_ack <= 1'h0;
			end_service <= 1'h0;
			data_in <= 8'h00;
			cnt <= 4'h0;
			second <= 1'h0;
			n_in <= 8'h00;
			last_status <= 8'h00;
		end
		else
		begin
			cnt <= ((svc_req && !svc_ack) || (request_strobe && !proc_ack)) ? cnt + 4'h1 : 4'h0;
			svc_ack <= svc_req && !svc_ack && (cnt >= dly);
			proc_ack <= take;
			if (take)
			begin
				// terminal carries count done or a dummy as the bench asks
				data_in <= second ? (svc_order_in ? to_in : to_out) : (svc_order_in ? ~data_in : order_byte);
				end_service <= second;
				second <= !second;
				if (svc_order_in && !second)
					last_status <= data_out;
				if (svc_order_in && second)
					n_in <= n_in + 8'h01;
			end
			else if (!proc_ack)
			begin
				data_in <= ~data_in;
				end_service <= ~end_service;
			end
		end
	end
endmodule
`default_nettype wire
